// [verilog/sd_host_bus_ctrl.sv]
/*
 Card bus control core: command start with init clocks, read-wait stall,
 error capture per bus mode, event flags and card bus clock control.
 Assumes a data path on ref_clk_i reporting events, and a link clock
 from which the card bus clock is divided.
*/
`timescale 1ns/1ps
`include "sdh_params.svh"

module sd_host_bus_ctrl (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire sdh_pkg::bus_mode_t mode_i,
    input wire logic sdio_multi_rd_i,
    input wire logic spi_multi_wr_i,
    input wire logic dma_en_i,
    input wire logic rd_wait_en_i,
    input wire logic rd_wait_restart_i,
    input wire logic bus_clock_start_i,
    input wire logic bus_clock_stop_i,
    input wire logic [`SDH_RATE_W-1:0] clk_rate_i,
    input wire logic spi_cs_en_i,
    input wire logic spi_cs_sel_i,
    input wire logic cmd_req_i,
    input wire logic cmd_init_i,
    input wire logic cmd_r1b_i,
    input wire logic cmd_sent_i,
    input wire logic resp_end_i,
    input wire logic xfer_active_i,
    input wire logic xfer_end_i,
    input wire logic rx_full_i,
    input wire logic tx_empty_i,
    input wire logic rx_ready_i,
    input wire logic tx_space_i,
    input wire logic card_busy_i,
    input wire sdh_pkg::err_t err_ev_i,
    input wire sdh_pkg::err_t err_clear_i,
    input wire sdh_pkg::irq_t irq_clear_i,
    input wire sdh_pkg::irq_t irq_mask_i,
    input wire logic rx_block_end_i,
    output logic cmd_go_o,
    output logic stop_token_o,
    output sdh_pkg::err_t status_o,
    output sdh_pkg::irq_t irq_status_o,
    output logic irq_o,
    output logic rd_stalled_o,
    output logic clock_enabled_o,
    output logic card_clk_o,
    output logic dat2_o,
    output logic dat2_oe_o,
    output logic [1:0] spi_cs_n_o
);

    function automatic sdh_pkg::err_t qualify(sdh_pkg::err_t e, sdh_pkg::bus_mode_t m);
        sdh_pkg::err_t q;
        logic spi;
        q = e;
        spi = (m == sdh_pkg::MODE_SPI);
        q.resp_crc = e.resp_crc & ~spi;
        q.rd_timeout = e.rd_timeout & ~spi;
        q.rd_token = e.rd_token & spi;
        q.spi_wr_rej = e.spi_wr_rej & spi;
        q.flash_err = e.flash_err & (m == sdh_pkg::MODE_SD);
        return q;
    endfunction : qualify

    // ---------------- System domain ----------------
    sdh_pkg::cmd_state_t state_q;
    sdh_pkg::link_ctl_t ctl_q;
    sdh_pkg::link_sts_t sts_s;
    sdh_pkg::err_t status_q;
    sdh_pkg::err_t qual;
    sdh_pkg::irq_t irq_q;
    sdh_pkg::irq_t irq_set;
    logic cmd_go_q;
    logic init_ev_q;
    logic restart_ev_q;
    logic init_done_p;
    logic run_q;
    logic stop_pend_q;
    logic stalled_d1_q;
    logic sent_q;
    logic resp_q;
    logic prog_wait_q;
    logic stop_tok_q;
    logic busy_s;
    logic cmd_both;

    sync_level #(.W(1)) u_busy_sync (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(card_busy_i),
        .q_o(busy_s)
    );

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_q <= sdh_pkg::CS_IDLE;
            cmd_go_q <= 1'b0;
            init_ev_q <= 1'b0;
        end
        else
        begin
            cmd_go_q <= 1'b0;
            init_ev_q <= 1'b0;
            unique case (state_q)
                sdh_pkg::CS_IDLE:
                begin
                    if (cmd_req_i && cmd_init_i)
                    begin
                        init_ev_q <= 1'b1;
                        state_q <= sdh_pkg::CS_INIT;
                    end
                    else if (cmd_req_i)
                        cmd_go_q <= 1'b1;
                end
                sdh_pkg::CS_INIT:
                begin
                    if (init_done_p)
                    begin
                        cmd_go_q <= 1'b1;
                        state_q <= sdh_pkg::CS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            run_q <= 1'b0;
            stop_pend_q <= 1'b0;
            ctl_q <= '0;
            ctl_q.rate <= `SDH_RATE_RST;
            restart_ev_q <= 1'b0;
        end
        else
        begin
            if (bus_clock_start_i)
                run_q <= 1'b1;
            else if (bus_clock_stop_i)
                run_q <= 1'b0;
            if (bus_clock_stop_i)
                stop_pend_q <= 1'b1;
            else if (bus_clock_start_i || !sts_s.clk_on)
                stop_pend_q <= 1'b0;
            ctl_q.run <= run_q;
            ctl_q.gate <= xfer_active_i & (rx_full_i | tx_empty_i);
            ctl_q.rw_allow <= rd_wait_en_i & sdio_multi_rd_i & (mode_i == sdh_pkg::MODE_SD);
            ctl_q.cs_act <= spi_cs_en_i & (mode_i == sdh_pkg::MODE_SPI);
            ctl_q.cs_sel <= spi_cs_sel_i;
            if (!run_q && !sts_s.clk_on)
                ctl_q.rate <= clk_rate_i;
            restart_ev_q <= rd_wait_restart_i;
        end
    end

    // end bit not checked, errors masked by bus mode
    assign qual = qualify(err_ev_i, mode_i);
    assign cmd_both = (sent_q | cmd_sent_i) & (resp_q | resp_end_i);

    always_comb
    begin
        irq_set = '0;
        irq_set.rd_stalled = sts_s.stalled & ~stalled_d1_q;
        irq_set.resp_fault = qual.resp_crc | qual.resp_timeout;
        irq_set.data_fault = qual.rd_crc | qual.wr_crc | qual.rd_timeout | qual.rd_token
            | qual.spi_wr_rej | qual.flash_err;
        irq_set.clk_halted = stop_pend_q & ~sts_s.clk_on & ~bus_clock_start_i;
        irq_set.cmd_done = cmd_both;
        irq_set.xfer_done = xfer_end_i | qual.rd_timeout;
        irq_set.prog_done = prog_wait_q & ~busy_s;
    end

    // sticky flags except rx_drain and tx_fill, set wins over clear
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            status_q <= '0;
            irq_q <= '0;
            stalled_d1_q <= 1'b0;
        end
        else
        begin
            status_q <= (status_q & ~err_clear_i) | qual;
            irq_q <= (irq_q & ~irq_clear_i) | irq_set;
            // buffer requests only for programmed I/O
            irq_q.rx_drain <= rx_ready_i & ~dma_en_i;
            irq_q.tx_fill <= tx_space_i & ~dma_en_i;
            stalled_d1_q <= sts_s.stalled;
        end
    end

    // wait for busy release after data or R1b
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            sent_q <= 1'b0;
            resp_q <= 1'b0;
            prog_wait_q <= 1'b0;
        end
        else
        begin
            sent_q <= (sent_q | cmd_sent_i) & ~cmd_both & ~cmd_go_q;
            resp_q <= (resp_q | resp_end_i) & ~cmd_both & ~cmd_go_q;
            if (xfer_end_i || (cmd_both && cmd_r1b_i))
                prog_wait_q <= 1'b1;
            else if (!busy_s)
                prog_wait_q <= 1'b0;
        end
    end

    // stop token on SPI multi-write rejection
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            stop_tok_q <= 1'b0;
        else
            stop_tok_q <= spi_multi_wr_i & (qual.wr_crc | qual.spi_wr_rej)
                & (mode_i == sdh_pkg::MODE_SPI);
    end

    assign cmd_go_o = cmd_go_q;
    assign stop_token_o = stop_tok_q;
    assign status_o = status_q;
    assign irq_status_o = irq_q;
    assign irq_o = |(irq_q & ~irq_mask_i);
    assign rd_stalled_o = sts_s.stalled;
    assign clock_enabled_o = sts_s.clk_on;

    // ---------------- Crossings ----------------
    logic lrst;
    sdh_pkg::link_ctl_t lctl;
    sdh_pkg::link_sts_t lsts;
    logic init_go_p;
    logic restart_p;
    logic init_fin;

    // processor reset reaches link side too
    sync_level #(.W(1)) u_lrst_sync (
        .clk_i(link_clk_i),
        .rst_i(1'b0),
        .d_i(rst_i),
        .q_o(lrst)
    );
    sync_level #(.W($bits(sdh_pkg::link_ctl_t))) u_ctl_sync (
        .clk_i(link_clk_i),
        .rst_i(lrst),
        .d_i(ctl_q),
        .q_o(lctl)
    );
    sync_level #(.W($bits(sdh_pkg::link_sts_t))) u_sts_sync (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(lsts),
        .q_o(sts_s)
    );
    event_cross u_init_go (
        .src_clk_i(ref_clk_i),
        .src_rst_i(rst_i),
        .pulse_i(init_ev_q),
        .dst_clk_i(link_clk_i),
        .dst_rst_i(lrst),
        .pulse_o(init_go_p)
    );
    event_cross u_restart (
        .src_clk_i(ref_clk_i),
        .src_rst_i(rst_i),
        .pulse_i(restart_ev_q),
        .dst_clk_i(link_clk_i),
        .dst_rst_i(lrst),
        .pulse_o(restart_p)
    );
    event_cross u_init_done (
        .src_clk_i(link_clk_i),
        .src_rst_i(lrst),
        .pulse_i(init_fin),
        .dst_clk_i(ref_clk_i),
        .dst_rst_i(rst_i),
        .pulse_o(init_done_p)
    );

    // ---------------- Link domain ----------------
    logic [`SDH_DIV_W-1:0] div_q;
    logic [`SDH_DIV_W-1:0] div_lim;
    logic [`SDH_INIT_CNT_W-1:0] init_cnt_q;
    logic init_busy_q;
    logic card_clk_q;
    logic stall_q;
    logic clk_on_q;
    logic [1:0] cs_n_q;
    logic run_en;
    logic tick;
    logic rise;

    // divide ratio from the rate setting
    assign div_lim = `SDH_DIV_W'((9'h1 << lctl.rate) - 9'h1);
    assign tick = (div_q == div_lim);
    // gate during an active transfer while rx full or tx empty
    assign run_en = init_busy_q | (lctl.run & ~lctl.gate);
    assign rise = tick & ~card_clk_q & run_en;
    assign init_fin = init_busy_q & rise & (init_cnt_q == `SDH_INIT_CLKS - 7'd1);

    always_ff @(posedge link_clk_i)
    begin
        if (lrst)
        begin
            div_q <= '0;
            card_clk_q <= 1'b0;
            clk_on_q <= 1'b0;
        end
        else
        begin
            clk_on_q <= run_en;
            if (tick)
            begin
                div_q <= '0;
                // Stops only in the low phase
                if (card_clk_q || run_en)
                    card_clk_q <= ~card_clk_q;
            end
            else
                div_q <= div_q + `SDH_DIV_W'd1;
        end
    end

    // count the init clock rising edges
    always_ff @(posedge link_clk_i)
    begin
        if (lrst)
        begin
            init_busy_q <= 1'b0;
            init_cnt_q <= '0;
        end
        else if (init_go_p)
        begin
            init_busy_q <= 1'b1;
            init_cnt_q <= '0;
        end
        else if (rise && init_busy_q)
        begin
            init_cnt_q <= init_cnt_q + 7'd1;
            if (init_fin)
                init_busy_q <= 1'b0;
        end
    end

    // hold DAT2 low from block end until restart
    always_ff @(posedge link_clk_i)
    begin
        if (lrst)
            stall_q <= 1'b0;
        else if (rx_block_end_i && lctl.rw_allow)
            stall_q <= 1'b1;
        else if (restart_p)
            stall_q <= 1'b0;
    end

    always_ff @(posedge link_clk_i)
    begin
        if (lrst)
            cs_n_q <= 2'b11;
        else if (lctl.cs_act && !init_busy_q && !init_go_p)
            cs_n_q <= lctl.cs_sel ? 2'b01 : 2'b10;
        else
            cs_n_q <= 2'b11;
    end

    assign lsts.stalled = stall_q;
    assign lsts.clk_on = clk_on_q;
    assign card_clk_o = card_clk_q;
    assign dat2_o = 1'b0;
    assign dat2_oe_o = stall_q;
    assign spi_cs_n_o = cs_n_q;

    // ---------------- Checks ----------------
    logic [`SDH_INIT_CNT_W:0] chk_rises_q;
    always_ff @(posedge link_clk_i)
    begin
        if (lrst || init_go_p)
            chk_rises_q <= '0;
        else if (init_busy_q && card_clk_q == 1'b0 && tick && run_en)
            chk_rises_q <= chk_rises_q + 8'd1;
    end

    sequence spi_reject_s;
        mode_i == sdh_pkg::MODE_SPI && spi_multi_wr_i && (err_ev_i.wr_crc || err_ev_i.spi_wr_rej);
    endsequence
    sequence token_pulse_s;
        stop_token_o ##1 1'b1;
    endsequence

    init_count_a: assert property (@(posedge link_clk_i) disable iff (lrst)
        $fell(init_busy_q) |-> chk_rises_q == 8'd80) else $error("init clock count wrong");
    cs_idle_a: assert property (@(posedge link_clk_i) disable iff (lrst)
        init_busy_q |=> spi_cs_n_o == 2'b11) else $error("chip select during init");
    stall_drive_a: assert property (@(posedge link_clk_i) disable iff (lrst)
        rx_block_end_i && lctl.rw_allow |=> dat2_oe_o && !dat2_o) else $error("DAT2 not held");
    gate_hold_a: assert property (@(posedge link_clk_i) disable iff (lrst)
        !run_en && !card_clk_q |=> !card_clk_q) else $error("clock ran while gated");
    resp_crc_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        err_ev_i.resp_crc && mode_i != sdh_pkg::MODE_SPI |=> status_o.resp_crc
        && irq_status_o.resp_fault) else $error("response CRC not flagged");
    rd_timeout_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        err_ev_i.rd_timeout && mode_i == sdh_pkg::MODE_SPI && !status_o.rd_timeout
        && !err_clear_i.rd_timeout |=> !status_o.rd_timeout) else $error("SPI read timeout");
    flash_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        err_ev_i.flash_err && mode_i == sdh_pkg::MODE_SD |=> status_o.flash_err
        && irq_status_o.data_fault) else $error("flash error lost");
    stop_token_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        spi_reject_s |=> token_pulse_s) else $error("no stop token");
    dma_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        dma_en_i ##1 dma_en_i |-> !irq_status_o.rx_drain && !irq_status_o.tx_fill)
        else $error("buffer request under DMA");
    cmd_done_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cmd_sent_i && resp_end_i |=> irq_status_o.cmd_done) else $error("command done lost");
    resume_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_wait_restart_i && !rx_block_end_i ##1 !rx_block_end_i [*8] |-> ##[0:40] !rd_stalled_o)
        else $error("stall not released");

endmodule : sd_host_bus_ctrl

// [verilog/sdh_params.svh]
/*
 Constants for the card bus control core.
 Assumes inclusion by bare name from the package and the top module.
*/
`ifndef SDH_PARAMS_SVH
`define SDH_PARAMS_SVH

// Card bus clocks sent before a command flagged for initialisation
`define SDH_INIT_CLKS 7'd80
`define SDH_INIT_CNT_W 7
// Rate field: card clock = link clock / 2^(rate+1)
`define SDH_RATE_W 3
`define SDH_RATE_RST 3'h7
`define SDH_DIV_W 8
// Synchroniser depth in flip-flops; not referenced by the core or its checks
`define SDH_SYNC_W 2

`endif

// [verilog/sdh_pkg.sv]
/*
 Types shared by the card bus control core.
 Assumes sdh_params.svh is on the include path.
*/
`include "sdh_params.svh"

package sdh_pkg;

    typedef enum logic [1:0] {
        MODE_MMC = 2'b00,
        MODE_SD = 2'b01,
        MODE_SPI = 2'b10
    } bus_mode_t;

    typedef enum logic {
        CS_IDLE = 1'b0,
        CS_INIT = 1'b1
    } cmd_state_t;

    typedef struct packed {
        logic resp_crc;
        logic resp_timeout;
        logic rd_crc;
        logic wr_crc;
        logic rd_timeout;
        logic rd_token;
        logic spi_wr_rej;
        logic flash_err;
    } err_t;

    typedef struct packed {
        logic rd_stalled;
        logic resp_fault;
        logic data_fault;
        logic tx_fill;
        logic rx_drain;
        logic clk_halted;
        logic cmd_done;
        logic xfer_done;
        logic prog_done;
    } irq_t;

    typedef struct packed {
        logic run;
        logic gate;
        logic rw_allow;
        logic cs_act;
        logic cs_sel;
        logic [`SDH_RATE_W-1:0] rate;
    } link_ctl_t;

    typedef struct packed {
        logic stalled;
        logic clk_on;
    } link_sts_t;

endpackage : sdh_pkg

// [verilog/sync_level.sv]
/*
 Two flip-flop level synchroniser, W bits wide.
 Assumes each bit is quasi-static or independent of the others.
*/
`timescale 1ns/1ps

module sync_level #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule : sync_level

// [verilog/event_cross.sv]
/*
 Single-cycle event crossing by toggle and synchroniser.
 Assumes source events are spaced wider than three destination cycles.
*/
`timescale 1ns/1ps

module event_cross (
    input wire logic src_clk_i,
    input wire logic src_rst_i,
    input wire logic pulse_i,
    input wire logic dst_clk_i,
    input wire logic dst_rst_i,
    output logic pulse_o
);

    logic tog_q;
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge src_clk_i)
    begin
        if (src_rst_i)
            tog_q <= 1'b0;
        else if (pulse_i)
            tog_q <= ~tog_q;
    end

    always_ff @(posedge dst_clk_i)
    begin
        if (dst_rst_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= tog_q;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign pulse_o = sync_q ^ last_q;

endmodule : event_cross

// [dv/card_model.sv]
/*
 Card side model: counts card clock rises, sends block ends, drives busy.
 Assumes the link clock from the bench and the card clock from the core.
*/
`timescale 1ns/1ps

module card_model (
    input wire logic link_clk_i,
    input wire logic card_clk_i,
    input wire logic blk_i,
    input wire logic busy_i,
    input wire logic cnt_clr_i,
    output logic rx_block_end_o,
    output logic card_busy_o,
    output int rises_o
);
    logic [2:0] blk_q = 3'h0;

    initial rx_block_end_o = 1'h0;
    assign card_busy_o = busy_i;
    // One block end per rising request
    always @(posedge link_clk_i)
    begin
        blk_q <= {blk_q[1:0], blk_i};
        rx_block_end_o <= blk_q[1] & ~blk_q[2];
    end
    always @(posedge card_clk_i or posedge cnt_clr_i)
    begin
        if (cnt_clr_i)
            rises_o <= 0;
        else
            rises_o <= rises_o + 1;
    end
endmodule : card_model

// [dv/tb_top.sv]
/*
 Self-checking bench for the card bus control core.
 Assumes the core and card_model are compiled before it.
*/
`timescale 1ns/1ps

module tb_top;
    logic ref_clk = 1'h0;
    logic link_clk = 1'h0;
    logic rst = 1'h1;
    sdh_pkg::bus_mode_t mode = sdh_pkg::MODE_MMC;
    logic mrd = 1'h0, mwr = 1'h0, dma = 1'h0, rw_en = 1'h0, rw_go = 1'h0;
    logic start = 1'h0, stop = 1'h0, cs_en = 1'h0, creq = 1'h0, cinit = 1'h0;
    logic sent = 1'h0, rend = 1'h0, xact = 1'h0, xend = 1'h0, full = 1'h0;
    logic rdy = 1'h0, space = 1'h0, busy = 1'h0, blk = 1'h0, clr = 1'h0;
    logic [7:0] ev = 8'h00, eclr = 8'h00;
    logic [8:0] iclr = 9'h000;
    logic [8:0] mask = 9'h000;
    logic [2:0] rate = 3'h0;
    logic r1b = 1'h0;
    logic cmd_go, stop_tok, irq, stalled, clk_en, card_clk, dat2, dat2_oe;
    logic blk_end, card_busy;
    logic [1:0] cs_n;
    sdh_pkg::err_t status;
    sdh_pkg::irq_t irqs;
    int rises;
    int mismatches = 0;
    int n_checks = 0;

    always #12.5 ref_clk = ~ref_clk;
    initial
    begin
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    sd_host_bus_ctrl DUT (.ref_clk_i(ref_clk), .rst_i(rst), .link_clk_i(link_clk),
        .mode_i(mode), .sdio_multi_rd_i(mrd), .spi_multi_wr_i(mwr), .dma_en_i(dma),
        .rd_wait_en_i(rw_en), .rd_wait_restart_i(rw_go), .bus_clock_start_i(start),
        .bus_clock_stop_i(stop), .clk_rate_i(rate), .spi_cs_en_i(cs_en),
        .spi_cs_sel_i(1'h0), .cmd_req_i(creq), .cmd_init_i(cinit), .cmd_r1b_i(r1b),
        .cmd_sent_i(sent), .resp_end_i(rend), .xfer_active_i(xact), .xfer_end_i(xend),
        .rx_full_i(full), .tx_empty_i(1'h0), .rx_ready_i(rdy), .tx_space_i(space),
        .card_busy_i(card_busy), .err_ev_i(ev), .err_clear_i(eclr), .irq_clear_i(iclr),
        .irq_mask_i(mask), .rx_block_end_i(blk_end), .cmd_go_o(cmd_go),
        .stop_token_o(stop_tok), .status_o(status), .irq_status_o(irqs), .irq_o(irq),
        .rd_stalled_o(stalled), .clock_enabled_o(clk_en), .card_clk_o(card_clk),
        .dat2_o(dat2), .dat2_oe_o(dat2_oe), .spi_cs_n_o(cs_n));

    card_model card (.link_clk_i(link_clk), .card_clk_i(card_clk), .blk_i(blk),
        .busy_i(busy), .cnt_clr_i(clr), .rx_block_end_o(blk_end),
        .card_busy_o(card_busy), .rises_o(rises));

    task automatic close_out();
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wait_on(input int sel, input logic lvl, input int lim);
        logic v;
        for (int i = 0; i < lim; i++)
        begin
            cyc(1);
            v = sel == 1 ? dat2_oe : sel == 2 ? stalled : clk_en;
            if (v === lvl)
                return;
        end
        mismatches++;
        close_out();
    endtask : wait_on

    task automatic clear_all();
        @(posedge ref_clk);
        eclr <= 8'hFF;
        iclr <= 9'h1FF;
        @(posedge ref_clk);
        eclr <= 8'h00;
        iclr <= 9'h000;
    endtask : clear_all

    task automatic t_rst();
        cyc(1);
        chk({status, irqs, dat2_oe, cs_n, stop_tok}, {17'h00000, 1'h0, 2'h3, 1'h0});
    endtask : t_rst

    task automatic t_init();
        logic bad;
        int i;
        bad = 1'h0;
        @(posedge ref_clk);
        mode <= sdh_pkg::MODE_SPI;
        cs_en <= 1'h1;
        clr <= 1'h1;
        @(posedge ref_clk);
        clr <= 1'h0;
        creq <= 1'h1;
        cinit <= 1'h1;
        @(posedge ref_clk);
        creq <= 1'h0;
        cinit <= 1'h0;
        for (i = 0; i < 2000 && cmd_go !== 1'h1; i++)
        begin
            cyc(1);
            bad |= rises > 0 && rises < 80 && cs_n !== 2'h3;
        end
        chk(i < 2000, 1'h1);
        if (i >= 2000)
            close_out();
        chk(rises, 80);
        chk(bad, 1'h0);
        cyc(30);
        chk(cs_n, 2'h2);
        repeat (2)
        begin
            @(posedge ref_clk);
            creq <= 1'h1;
            @(posedge ref_clk);
            creq <= 1'h0;
            #1;
            chk(cmd_go, 1'h1);
        end
    endtask : t_init

    task automatic t_err();
        logic [7:0] ok [3] = '{8'hF8, 8'hF9, 8'h76};
        logic [7:0] e;
        for (int m = 0; m < 3; m++)
            for (int p = 0; p < 2; p++)
            begin
                e = p ? 8'h3F : 8'hC0;
                @(posedge ref_clk);
                mode <= sdh_pkg::bus_mode_t'(m);
                ev <= e;
                @(posedge ref_clk);
                ev <= 8'h00;
                #1;
                chk(status, ok[m] & e);
                chk({irqs.resp_fault, irqs.data_fault, irq},
                    {|(ok[m] & e & 8'hC0), |(ok[m] & e & 8'h3F), 1'h1});
                clear_all();
            end
    endtask : t_err

    task automatic t_stop();
        logic [7:0] e [3] = '{8'h10, 8'h02, 8'h20};
        @(posedge ref_clk);
        mode <= sdh_pkg::MODE_SPI;
        mwr <= 1'h1;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge ref_clk);
            ev <= e[k];
            @(posedge ref_clk);
            ev <= 8'h00;
            #1;
            chk(stop_tok, k < 2);
        end
        // error token answered by an abort command
        @(posedge ref_clk);
        ev <= 8'h04;
        creq <= 1'h1;
        @(posedge ref_clk);
        ev <= 8'h00;
        creq <= 1'h0;
        #1;
        chk({status.rd_token, cmd_go}, 2'h3);
        clear_all();
        mwr <= 1'h0;
    endtask : t_stop

    task automatic t_fifo();
        @(posedge ref_clk);
        dma <= 1'h1;
        rdy <= 1'h1;
        space <= 1'h1;
        cyc(3);
        chk({irqs.rx_drain, irqs.tx_fill}, 2'h0);
        @(posedge ref_clk);
        dma <= 1'h0;
        cyc(3);
        chk({irqs.rx_drain, irqs.tx_fill}, 2'h3);
        @(posedge ref_clk);
        rdy <= 1'h0;
        space <= 1'h0;
    endtask : t_fifo

    task automatic t_done();
        clear_all();
        rend <= 1'h1;
        @(posedge ref_clk);
        rend <= 1'h0;
        cyc(3);
        chk(irqs.cmd_done, 1'h0);
        @(posedge ref_clk);
        sent <= 1'h1;
        busy <= 1'h1;
        @(posedge ref_clk);
        sent <= 1'h0;
        cyc(4);
        chk(irqs.cmd_done, 1'h1);
        @(posedge ref_clk);
        xend <= 1'h1;
        @(posedge ref_clk);
        xend <= 1'h0;
        cyc(6);
        chk({irqs.xfer_done, irqs.prog_done}, 2'h2);
        @(posedge ref_clk);
        busy <= 1'h0;
        cyc(6);
        chk(irqs.prog_done, 1'h1);
        @(posedge ref_clk);
        busy <= 1'h1;
        clear_all();
        // R1b command waits for busy release
        r1b <= 1'h1;
        sent <= 1'h1;
        rend <= 1'h1;
        @(posedge ref_clk);
        sent <= 1'h0;
        rend <= 1'h0;
        cyc(6);
        chk({irqs.cmd_done, irqs.prog_done}, 2'h2);
        @(posedge ref_clk);
        busy <= 1'h0;
        r1b <= 1'h0;
        cyc(6);
        chk(irqs.prog_done, 1'h1);
    endtask : t_done

    task automatic t_rdwait();
        @(posedge ref_clk);
        mode <= sdh_pkg::MODE_SD;
        mrd <= 1'h1;
        rw_en <= 1'h1;
        mask <= 9'h0FF;
        cyc(30);
        chk(irq, 1'h0);
        // receive side kept drained, full stays low
        blk <= 1'h1;
        wait_on(1, 1'h1, 60);
        chk({dat2_oe, dat2}, 2'h2);
        wait_on(2, 1'h1, 20);
        cyc(1);
        chk({irqs.rd_stalled, irq}, 2'h3);
        @(posedge ref_clk);
        blk <= 1'h0;
        rw_go <= 1'h1;
        @(posedge ref_clk);
        rw_go <= 1'h0;
        wait_on(1, 1'h0, 60);
        wait_on(2, 1'h0, 20);
        @(posedge ref_clk);
        mode <= sdh_pkg::MODE_MMC;
        mask <= 9'h1FF;
        cyc(30);
        chk(irq, 1'h0);
        blk <= 1'h1;
        cyc(40);
        chk(dat2_oe, 1'h0);
        blk <= 1'h0;
    endtask : t_rdwait

    task automatic t_clk();
        int n;
        @(posedge ref_clk);
        start <= 1'h1;
        @(posedge ref_clk);
        start <= 1'h0;
        wait_on(3, 1'h1, 40);
        clr <= 1'h1;
        cyc(1);
        clr <= 1'h0;
        cyc(100);
        chk(rises >= 9 && rises <= 11, 1'h1);
        @(posedge ref_clk);
        xact <= 1'h1;
        full <= 1'h1;
        cyc(20);
        n = rises;
        cyc(40);
        chk(rises == n, 1'h1);
        @(posedge ref_clk);
        full <= 1'h0;
        cyc(40);
        chk(rises > n + 2, 1'h1);
        @(posedge ref_clk);
        xact <= 1'h0;
        stop <= 1'h1;
        @(posedge ref_clk);
        stop <= 1'h0;
        wait_on(3, 1'h0, 40);
        cyc(4);
        chk(irqs.clk_halted, 1'h1);
        @(posedge ref_clk);
        rate <= 3'h1;
        start <= 1'h1;
        @(posedge ref_clk);
        start <= 1'h0;
        wait_on(3, 1'h1, 40);
        clr <= 1'h1;
        cyc(1);
        clr <= 1'h0;
        cyc(100);
        chk(rises >= 4 && rises <= 6, 1'h1);
    endtask : t_clk

    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        cyc(24);
    endtask : do_reset

    initial
    begin
        do_reset();
        t_rst();
        t_init();
        t_err();
        t_stop();
        t_fifo();
        t_done();
        t_rdwait();
        t_clk();
        do_reset();
        t_rst();
        close_out();
    end
endmodule : tb_top
